// ### gpp_pkg.sv
// package of register map, widths and carriers for the general-purpose port block
package gpp_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int PW = 8;
  localparam int CW = 7;
  // register indices; one 32-bit word per register, so the byte address is four times the index
  localparam int            IDX_B_DATA    = 1;
  localparam int            IDX_C_DATA    = 2;
  localparam int            IDX_B_DIR     = 5;
  localparam int            IDX_A_PULLUP  = 13;
  localparam int            IDX_C_DIR     = 16;
  localparam int            IDX_C_PULLUP  = 17;
  localparam int            IDX_ADC_SEL   = 18;
  localparam logic [AW-1:0] OFS_B_DATA    = AW'(IDX_B_DATA * 4);
  localparam logic [AW-1:0] OFS_C_DATA    = AW'(IDX_C_DATA * 4);
  localparam logic [AW-1:0] OFS_B_DIR     = AW'(IDX_B_DIR * 4);
  localparam logic [AW-1:0] OFS_A_PULLUP  = AW'(IDX_A_PULLUP * 4);
  localparam logic [AW-1:0] OFS_C_DIR     = AW'(IDX_C_DIR * 4);
  localparam logic [AW-1:0] OFS_C_PULLUP  = AW'(IDX_C_PULLUP * 4);
  localparam logic [AW-1:0] OFS_ADC_SEL   = AW'(IDX_ADC_SEL * 4);
  localparam logic [PW-1:0] RST_DIR       = 8'h00;
  localparam logic [PW-1:0] RST_PULLUP    = 8'h00;
  localparam logic [4:0]    RST_ADC_SEL   = 5'h1F;
  localparam logic [4:0]    ADC_NONE      = 5'h1F;
  localparam logic [1:0]    RESP_OKAY     = 2'h0;
  localparam logic [1:0]    RESP_SLVERR   = 2'h2;
  // analog channel select: enable plus 3-bit pin index
  typedef struct packed {
    logic       en;
    logic [2:0] pin;
  } gpp_adc_sel_t;
  typedef struct packed {
    logic [PW-1:0] out;
    logic [PW-1:0] oe;
    logic [PW-1:0] pu;
  } gpp_pins_t;
endpackage

// ### gpp_top.sv
// general-purpose port block: ports a (pullups), b and c with AXI4-Lite registers
`timescale 1ns/1ps
// What this block does and what it expects of software
// RL1: port a pullup bits enable pullups, reset 0
// RL2: port a pullup only while pin input
// RL3: output direction forces pullup off, input restores
// RL4: port b data latch, not reset
// RL5: port b direction 1 drives pin
// RL6: reset clears port b direction
// RL7: port b read: latch if output, else pin
// RL8: data writes always update latch; the code updates it only when S_AXI_WSTRB bit 0 is set
// RL9: analog select forces port b pin input
// RL10: software loads latch before setting output
// RL11: port c seven pins, latch kept through reset
// RL12: port c direction drives pin, reset clears
// RL13: port c read: latch if output, else pin
// RL14: port c pullups only on input pins
// RL15: single-access registers, pins sampled on clock
module gpp_top
  import gpp_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  input  wire logic [gpp_pkg::AW-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [gpp_pkg::DW-1:0] S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [gpp_pkg::AW-1:0] S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [gpp_pkg::DW-1:0]     S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire logic [gpp_pkg::PW-1:0] PORT_A_PIN_IN,
  output logic [gpp_pkg::PW-1:0]     PORT_A_PULLUP_ON,
  input  wire logic [gpp_pkg::PW-1:0] PORT_A_DIRECTION,
  input  wire logic [gpp_pkg::PW-1:0] PORT_B_PIN_IN,
  output logic [gpp_pkg::PW-1:0]     PORT_B_PIN_OUT,
  output logic [gpp_pkg::PW-1:0]     PORT_B_PIN_OE,
  output logic [gpp_pkg::PW-1:0]     ANALOG_CHANNEL_PINS,
  input  wire logic [gpp_pkg::CW-1:0] PORT_C_PIN_IN,
  output logic [gpp_pkg::CW-1:0]     PORT_C_PIN_OUT,
  output logic [gpp_pkg::CW-1:0]     PORT_C_PIN_OE,
  output logic [gpp_pkg::CW-1:0]     PORT_C_PULLUP_ON
);
  import gpp_pkg::*;

  logic [PW-1:0] port_a_pullup_enable;
  logic [PW-1:0] port_b_data_latch;
  logic [PW-1:0] port_b_direction;
  logic [CW-1:0] port_c_data_latch;
  logic [CW-1:0] port_c_direction;
  logic [CW-1:0] port_c_pullup_enable;
  logic [4:0]    adc_sel;
  logic [PW-1:0] b_pin_q;
  logic [CW-1:0] c_pin_q;
  logic [PW-1:0] analog_mask;

  logic [AW-1:0] aw_addr;
  logic          aw_have;
  logic [DW-1:0] w_data;
  logic [3:0]    w_strb;
  logic          w_have;
  logic          wr_go;
  logic          rd_go;
  logic [DW-1:0] next_rdata;
  logic [1:0]    next_rresp;
  logic          wr_hit;

  // pins sampled once per clock for readback
  always_ff @(posedge SYS_CLK) begin
    b_pin_q <= PORT_B_PIN_IN; // RL15
    c_pin_q <= PORT_C_PIN_IN; // RL15
  end

  // analog select: values >= 8 mean no pin taken; bits 4 and 3 clear plus index picks a pin
  always_comb begin
    analog_mask = '0;
    if (adc_sel[4:3] == 2'h0) begin
      analog_mask[adc_sel[2:0]] = 1'b1; // RL9
    end
  end

  // address and data may arrive in either order; each is held until both are present
  assign wr_go = aw_have && w_have && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_have       <= 1'b0;
      aw_addr       <= '0;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_go) begin
      aw_have       <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have       <= 1'b1;
      aw_addr       <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      w_have       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_go) begin
      w_have       <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have       <= 1'b1;
      w_data       <= S_AXI_WDATA;
      w_strb       <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_have && !S_AXI_BVALID;
    end
  end

  always_comb begin
    wr_hit = (aw_addr == OFS_B_DATA) || (aw_addr == OFS_C_DATA) || (aw_addr == OFS_B_DIR) ||
             (aw_addr == OFS_A_PULLUP) || (aw_addr == OFS_C_DIR) || (aw_addr == OFS_C_PULLUP) ||
             (aw_addr == OFS_ADC_SEL);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1; // RL15
      S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // data latches have no reset term: their contents survive reset
  always_ff @(posedge SYS_CLK) begin
    if (wr_go && w_strb[0]) begin
      if (aw_addr == OFS_B_DATA) begin
        port_b_data_latch <= w_data[PW-1:0]; // RL4 RL8
      end else if (aw_addr == OFS_C_DATA) begin
        port_c_data_latch <= w_data[CW-1:0]; // RL11 RL8
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      port_b_direction     <= RST_DIR; // RL6
      port_c_direction     <= RST_DIR[CW-1:0]; // RL12
      port_a_pullup_enable <= RST_PULLUP; // RL1
      port_c_pullup_enable <= RST_PULLUP[CW-1:0];
      adc_sel              <= RST_ADC_SEL;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == OFS_B_DIR) begin
        port_b_direction <= w_data[PW-1:0]; // RL5
      end else if (aw_addr == OFS_C_DIR) begin
        port_c_direction <= w_data[CW-1:0]; // RL12
      end else if (aw_addr == OFS_A_PULLUP) begin
        port_a_pullup_enable <= w_data[PW-1:0]; // RL1
      end else if (aw_addr == OFS_C_PULLUP) begin
        port_c_pullup_enable <= w_data[CW-1:0]; // RL14
      end else if (aw_addr == OFS_ADC_SEL) begin
        adc_sel <= w_data[4:0];
      end
    end
  end

  // read mux; analog pins read as inputs since the buffer is forced off
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (S_AXI_ARADDR == OFS_B_DATA) begin
      next_rdata[PW-1:0] = (port_b_direction & ~analog_mask & port_b_data_latch) |
                           (~(port_b_direction & ~analog_mask) & b_pin_q); // RL7
    end else if (S_AXI_ARADDR == OFS_C_DATA) begin
      next_rdata[CW-1:0] = (port_c_direction & port_c_data_latch) | (~port_c_direction & c_pin_q); // RL13
    end else if (S_AXI_ARADDR == OFS_B_DIR) begin
      next_rdata[PW-1:0] = port_b_direction;
    end else if (S_AXI_ARADDR == OFS_A_PULLUP) begin
      next_rdata[PW-1:0] = port_a_pullup_enable;
    end else if (S_AXI_ARADDR == OFS_C_DIR) begin
      next_rdata[CW-1:0] = port_c_direction;
    end else if (S_AXI_ARADDR == OFS_C_PULLUP) begin
      next_rdata[CW-1:0] = port_c_pullup_enable;
    end else if (S_AXI_ARADDR == OFS_ADC_SEL) begin
      next_rdata[4:0] = adc_sel;
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1; // RL15
      S_AXI_RDATA   <= next_rdata;
      S_AXI_RRESP   <= next_rresp;
    end else if (S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // pin drive outputs registered; glitch-free turn-on relies on software loading the latch first
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PORT_B_PIN_OE       <= '0;
      PORT_B_PIN_OUT      <= '0;
      PORT_C_PIN_OE       <= '0;
      PORT_C_PIN_OUT      <= '0;
      PORT_A_PULLUP_ON    <= '0;
      PORT_C_PULLUP_ON    <= '0;
      ANALOG_CHANNEL_PINS <= '0;
    end else begin
      PORT_B_PIN_OE       <= port_b_direction & ~analog_mask; // RL5 RL9 RL10
      PORT_B_PIN_OUT      <= port_b_data_latch & ~analog_mask; // RL9
      ANALOG_CHANNEL_PINS <= analog_mask; // RL9
      PORT_C_PIN_OE       <= port_c_direction; // RL12
      PORT_C_PIN_OUT      <= port_c_data_latch; // RL11
      PORT_A_PULLUP_ON    <= port_a_pullup_enable & ~PORT_A_DIRECTION; // RL2 RL3
      PORT_C_PULLUP_ON    <= port_c_pullup_enable & ~port_c_direction; // RL14
    end
  end
endmodule

// ### gpp_pins.sv
// pad model for ports b and c: drive, pullup or outside level
`timescale 1ns/1ps
module gpp_pins #(parameter int N = 8) (
  input  wire logic [N-1:0] oe,
  input  wire logic [N-1:0] out,
  input  wire logic [N-1:0] pu,
  input  wire logic [N-1:0] ext,
  output wire logic [N-1:0] lvl
);
  // an undriven pad with pullup reads high, else the outside level
  assign lvl = (oe & out) | (~oe & pu) | (~oe & ~pu & ext);
endmodule

// ### gpp_assertions.sv
// protocol and pin checks on the port block
`timescale 1ns/1ps
module gpp_assertions (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [7:0]  PORT_A_PULLUP_ON,
  input wire logic [7:0]  PORT_A_DIRECTION,
  input wire logic [7:0]  PORT_B_PIN_OUT,
  input wire logic [7:0]  PORT_B_PIN_OE,
  input wire logic [7:0]  ANALOG_CHANNEL_PINS,
  input wire logic [6:0]  PORT_C_PIN_OE,
  input wire logic [6:0]  PORT_C_PULLUP_ON
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence wr_taken; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence rd_taken; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  wr_resp_a: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  rd_resp_a: assert property (rd_taken |-> ##[1:2] S_AXI_RVALID) else $error("read answer late");
  wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("write taken while busy");
  rd_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
  rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper bits set");
  a_pullup_a: assert property ((PORT_A_PULLUP_ON & $past(PORT_A_DIRECTION)) == 8'h00)
    else $error("pullup on output pin");
  c_pullup_a: assert property ((PORT_C_PULLUP_ON & PORT_C_PIN_OE) == 7'h00) else $error("port c pullup");
  analog_pin_a: assert property ((ANALOG_CHANNEL_PINS & (PORT_B_PIN_OE | PORT_B_PIN_OUT)) == 8'h00)
    else $error("analog pin driven");
  analog_one_a: assert property ($onehot0(ANALOG_CHANNEL_PINS)) else $error("several analog pins");
endmodule

// ### testbench.sv
// register and pin tests for the port block
`timescale 1ns/1ps
module testbench;
  import gpp_pkg::*;
  logic SYS_CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PORT_A_PIN_IN, PORT_A_DIRECTION, PORT_A_PULLUP_ON, b_ext;
  logic [7:0] PORT_B_PIN_OUT, PORT_B_PIN_OE, ANALOG_CHANNEL_PINS;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rd_r, wr_r;
  logic [6:0] PORT_C_PIN_OUT, PORT_C_PIN_OE, PORT_C_PULLUP_ON;
  wire [7:0] PORT_B_PIN_IN;
  wire [6:0] PORT_C_PIN_IN;
  int num_errors = 0, total_checks = 0, cyc = 0;
  gpp_top dut (.*);
  gpp_pins #(8) pb (.oe(PORT_B_PIN_OE), .out(PORT_B_PIN_OUT), .pu(8'h00), .ext(b_ext), .lvl(PORT_B_PIN_IN));
  gpp_pins #(7) pc (.oe(PORT_C_PIN_OE), .out(PORT_C_PIN_OUT), .pu(PORT_C_PULLUP_ON), .ext(7'h00), .lvl(PORT_C_PIN_IN));
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data are offered together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    {ta, tw} = 2'b00;
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    while (!(ta && tw)) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY && !ta) begin ta = 1'b1; S_AXI_AWVALID <= 1'b0; end
      if (S_AXI_WREADY && !tw) begin tw = 1'b1; S_AXI_WVALID <= 1'b0; end
    end
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    wr_r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    {rd_d, rd_r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
    @(posedge SYS_CLK);
    chk(rd_d, exp);
  endtask
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    {RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {S_AXI_AWADDR, S_AXI_ARADDR, PORT_A_PIN_IN, PORT_A_DIRECTION} = 32'h0;
    {S_AXI_WDATA, S_AXI_WSTRB, b_ext} = {32'h0, 4'hF, 8'h3C};
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    rd(OFS_A_PULLUP, 32'h0);
    rd(OFS_B_DIR, 32'h0);
    rd(OFS_C_DIR, 32'h0);
    rd(OFS_C_PULLUP, 32'h0);
    wr(OFS_B_DATA, 32'hA5);
    wr(OFS_B_DIR, 32'h0F);
    chk(32'(PORT_B_PIN_OE), 32'h0F);
    chk(32'(PORT_B_PIN_OUT), 32'hA5);
    rd(OFS_B_DATA, 32'h35);
    wr(OFS_B_DATA, 32'h5A);
    rd(OFS_B_DATA, 32'h3A);
    wr(OFS_ADC_SEL, 32'h02);
    chk(32'(ANALOG_CHANNEL_PINS), 32'h04);
    chk(32'(PORT_B_PIN_OE), 32'h0B);
    wr(OFS_ADC_SEL, 32'(ADC_NONE));
    wr(OFS_C_DATA, 32'h55);
    wr(OFS_C_DIR, 32'h70);
    wr(OFS_C_PULLUP, 32'h0F);
    chk(32'(PORT_C_PIN_OE), 32'h70);
    chk(32'(PORT_C_PULLUP_ON), 32'h0F);
    rd(OFS_C_DATA, 32'h5F);
    wr(OFS_A_PULLUP, 32'hFF);
    PORT_A_DIRECTION <= 8'hF0;
    repeat (2) @(posedge SYS_CLK);
    chk(32'(PORT_A_PULLUP_ON), 32'h0F);
    PORT_A_DIRECTION <= 8'h00;
    repeat (2) @(posedge SYS_CLK);
    chk(32'(PORT_A_PULLUP_ON), 32'hFF);
    rd(8'h80, 32'h0);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    wr(8'h80, 32'hFF);
    chk(32'(wr_r), 32'(RESP_SLVERR));
    S_AXI_WSTRB <= 4'h0;
    wr(OFS_B_DIR, 32'hFF);
    chk(32'(wr_r), 32'(RESP_OKAY));
    S_AXI_WSTRB <= 4'hF;
    rd(OFS_B_DIR, 32'h0F);
    RST <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    rd(OFS_B_DIR, 32'h0);
    wr(OFS_B_DIR, 32'hFF);
    rd(OFS_B_DATA, 32'h5A);
    wr(OFS_C_DIR, 32'h7F);
    rd(OFS_C_DATA, 32'h55);
    complete_run;
  end
endmodule
bind gpp_top gpp_assertions chk_i (.*);
